// file: rtl/sacp_parser.sv
// Command frame parser and reply sequencer for the acquisition module
`timescale 1ns/1ps
module sacp_parser #(
  parameter int ADC_W = sacp_pkg::ADC_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Received bytes from the serial engine
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // Reply bytes to the serial engine
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  // Converter
  output logic conv_req_o,
  output logic [sacp_pkg::CHAN_W-1:0] conv_chan_o,
  input wire logic conv_ack_i,
  input wire logic [ADC_W-1:0] conv_data_i,
  // Digital I/O pins
  input wire logic din_i,
  output logic dout_o
);
  import sacp_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_start(input logic [7:0] b);
    return (b == START_STD) || (b == START_EXT);
  endfunction

  function automatic logic chan_ok(input logic [7:0] b);
    return (b <= CHAN_MAX) || ((b >= TEST_LO) && (b <= TEST_HI));
  endfunction

  // Byte of a reply by position: 0 upper, 1 ~upper, 2 lower, 3 ~lower
  function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic dig,
                                          input logic [ADC_W-1:0] w,
                                          input logic [7:0] st);
    logic [7:0] b;
    b = 8'h00;
    if (dig) begin
      b = st;
    end else begin
      b = idx[1] ? w[7:0] : 8'(w[ADC_W-1:8]);
    end
    return idx[0] ? ~b : b;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sacp_state_e state_r;
  sacp_cmd_e cmd_r;
  logic ext_r;
  logic [7:0] ltr1_r;
  logic [7:0] data_r;
  logic [CHAN_W-1:0] chan_r;
  logic [ADC_W-1:0] res_r;
  logic [1:0] idx_r;
  logic din_s;
  logic avg_done;
  logic [ADC_W-1:0] avg_res;
  logic [7:0] status;
  logic hs;
  logic [1:0] step;
  logic [1:0] last_idx;
  logic send_done;
  logic more_chan;
  logic dig_go;
  logic an_go;
  logic exec;
  logic [7:0] exec_byte;
  logic avg_start;
  logic [CHAN_W-1:0] avg_chan;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  sacp_sync3 u_din_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .pin_i(din_i),
    .level_o(din_s)
  );

  sacp_avg4 #(.ADC_W(ADC_W)) u_avg (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .start_i(avg_start),
    .chan_i(avg_chan),
    .done_o(avg_done),
    .avg_o(avg_res),
    .req_o(conv_req_o),
    .chan_o(conv_chan_o),
    .ack_i(conv_ack_i),
    .data_i(conv_data_i)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Status byte: undefined bits read as zero
  always_comb begin
    status = 8'h00;
    status[STAT_OUT_BIT] = dout_o;
    status[STAT_IN_BIT] = din_s;
  end

  // Reply pacing; plain frames skip the complement positions
  assign hs = tx_valid_o && tx_ready_i;
  assign step = ext_r ? 2'd1 : 2'd2;
  assign last_idx = (cmd_r == CMD_DIG) ? {1'b0, ext_r} : {1'b1, ext_r};
  assign send_done = (state_r == ST_SEND) && hs && (idx_r == last_idx);
  assign more_chan = (chan_r != '0) && (8'(chan_r) <= CHAN_MAX);

  // Command start points
  assign dig_go = (state_r == ST_CMD2) && rx_valid_i && (ltr1_r == LTR_R) &&
                  (rx_data_i == LTR_D);
  assign an_go = (state_r == ST_CONV) && avg_done;
  assign exec = rx_valid_i && (((state_r == ST_DATA) && !ext_r) ||
                ((state_r == ST_CPL) && (rx_data_i == ~data_r)));
  assign exec_byte = (state_r == ST_DATA) ? rx_data_i : data_r;

  // Start averaging for the first channel or the next one down
  assign avg_start = (exec && (cmd_r == CMD_AN) && chan_ok(exec_byte)) ||
                     (send_done && (cmd_r == CMD_AN) && more_chan);
  assign avg_chan = exec ? exec_byte[CHAN_W-1:0] : chan_r - CHAN_W'(1);

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  // Bytes arriving during a reply are dropped; the host waits for answers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_START;
      ext_r <= 1'b0;
      ltr1_r <= 8'h00;
      data_r <= 8'h00;
      cmd_r <= CMD_AN;
    end else begin
      unique case (state_r)
        ST_START: begin
          if (rx_valid_i && is_start(rx_data_i)) begin
            state_r <= ST_ADDR;
            ext_r <= (rx_data_i == START_EXT);
          end
        end
        ST_ADDR: begin
          if (rx_valid_i && (rx_data_i == MOD_ADDR)) begin
            state_r <= ST_CMD1;
          end else if (rx_valid_i) begin
            state_r <= is_start(rx_data_i) ? ST_ADDR : ST_START;
            ext_r <= (rx_data_i == START_EXT);
          end
        end
        ST_CMD1: begin
          if (rx_valid_i && ((rx_data_i == LTR_R) || (rx_data_i == LTR_S))) begin
            state_r <= ST_CMD2;
            ltr1_r <= rx_data_i;
          end else if (rx_valid_i) begin
            state_r <= is_start(rx_data_i) ? ST_ADDR : ST_START;
            ext_r <= (rx_data_i == START_EXT);
          end
        end
        ST_CMD2: begin
          if (rx_valid_i) begin
            if ((ltr1_r == LTR_R) && (rx_data_i == LTR_A)) begin
              state_r <= ST_DATA;
              cmd_r <= CMD_AN;
            end else if (dig_go) begin
              state_r <= ST_SEND;
              cmd_r <= CMD_DIG;
            end else if ((ltr1_r == LTR_S) && (rx_data_i == LTR_O)) begin
              state_r <= ST_DATA;
              cmd_r <= CMD_SET;
            end else begin
              state_r <= is_start(rx_data_i) ? ST_ADDR : ST_START;
              ext_r <= (rx_data_i == START_EXT);
            end
          end
        end
        ST_DATA, ST_CPL: begin
          if (rx_valid_i && (state_r == ST_DATA) && ext_r) begin
            state_r <= ST_CPL;
            data_r <= rx_data_i;
          end else if (exec) begin
            if ((cmd_r == CMD_AN) && chan_ok(exec_byte)) begin
              state_r <= ST_CONV;
            end else begin
              state_r <= ST_START;
            end
          end else if (rx_valid_i) begin
            state_r <= is_start(rx_data_i) ? ST_ADDR : ST_START;
            ext_r <= (rx_data_i == START_EXT);
          end
        end
        ST_CONV: begin
          if (an_go) begin
            state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (send_done) begin
            state_r <= avg_start ? ST_CONV : ST_START;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel, result and byte position
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chan_r <= '0;
      res_r <= '0;
      idx_r <= 2'd0;
    end else begin
      if (avg_start) begin
        chan_r <= avg_chan;
      end
      if (an_go || dig_go) begin
        res_r <= avg_res;
        idx_r <= 2'd0;
      end else if (hs && !send_done) begin
        idx_r <= idx_r + step;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply byte register
  // ----------------------------------------------------------------
  // Data are built into a flop so the serial engine sees a stable byte
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (dig_go || an_go) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= tx_byte(2'd0, dig_go, avg_res, status);
    end else if (hs && !send_done) begin
      // Complement is taken from the byte just sent, so a moving pin cannot split the pair
      tx_data_o <= (ext_r && !idx_r[0]) ? ~tx_data_o :
                   tx_byte(idx_r + step, cmd_r == CMD_DIG, res_r, status);
    end else if (hs) begin
      tx_valid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Digital output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dout_o <= DOUT_RST[DOUT_BIT];
    end else if (exec && (cmd_r == CMD_SET)) begin
      dout_o <= exec_byte[DOUT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  property p_set_out;
    exec && (cmd_r == CMD_SET) |=> (dout_o == $past(exec_byte[0])) && !tx_valid_o;
  endproperty
  a_set_out: assert property (p_set_out) else $error("output level wrong");

  property p_no_reply;
    exec && (cmd_r == CMD_SET) |=> (!tx_valid_o) [*3];
  endproperty
  a_no_reply: assert property (p_no_reply) else $error("reply after set");

  property p_descend;
    send_done && (cmd_r == CMD_AN) && more_chan |=> chan_r == $past(chan_r) - CHAN_W'(1);
  endproperty
  a_descend: assert property (p_descend) else $error("channel order wrong");

  property p_msb_first;
    an_go |=> tx_valid_o && (tx_data_o == 8'($past(avg_res[ADC_W-1:8])));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("upper byte not first");

  property p_cpl_follows;
    hs && ext_r && !idx_r[0] && !send_done |=> tx_data_o == ~$past(tx_data_o);
  endproperty
  a_cpl_follows: assert property (p_cpl_follows) else $error("no complement");

  property p_bad_cpl;
    (state_r == ST_CPL) && rx_valid_i && (rx_data_i != ~data_r) |=>
      (state_r inside {ST_START, ST_ADDR}) && !tx_valid_o;
  endproperty
  a_bad_cpl: assert property (p_bad_cpl) else $error("bad complement accepted");

  property p_bad_addr;
    (state_r == ST_ADDR) && rx_valid_i && (rx_data_i != MOD_ADDR) |=>
      state_r inside {ST_START, ST_ADDR};
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("wrong address accepted");

  property p_status;
    dig_go |=> tx_data_o == {4'h0, $past(din_s), 2'b00, $past(dout_o)};
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  property p_bad_chan;
    exec && (cmd_r == CMD_AN) && !chan_ok(exec_byte) |=> state_r == ST_START;
  endproperty
  a_bad_chan: assert property (p_bad_chan) else $error("bad channel accepted");
endmodule

// file: rtl/sacp_pkg.sv
// Constants and types shared by the serial acquisition command parser
package sacp_pkg;
  // ----------------------------------------------------------------
  // Frame bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] START_STD = 8'h21;
  localparam logic [7:0] START_EXT = 8'h23;
  localparam logic [7:0] MOD_ADDR = 8'h30;
  localparam logic [7:0] LTR_R = 8'h52;
  localparam logic [7:0] LTR_A = 8'h41;
  localparam logic [7:0] LTR_D = 8'h44;
  localparam logic [7:0] LTR_S = 8'h53;
  localparam logic [7:0] LTR_O = 8'h4F;

  // ----------------------------------------------------------------
  // Channel selection and status layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAN_MAX = 8'h05;
  localparam logic [7:0] TEST_LO = 8'h0B;
  localparam logic [7:0] TEST_HI = 8'h0D;
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_IN_BIT = 3;
  localparam int DOUT_BIT = 0;
  localparam int CHAN_W = 4;
  localparam int ADC_W = 12;
  localparam int AVG_N = 4;
  localparam int AVG_SUM_W = 14;
  localparam logic [13:0] AVG_ROUND = 14'h0002;
  localparam logic [7:0] DOUT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_START, ST_ADDR, ST_CMD1, ST_CMD2, ST_DATA, ST_CPL, ST_CONV, ST_SEND
  } sacp_state_e;
  typedef enum logic [1:0] {CMD_AN, CMD_DIG, CMD_SET} sacp_cmd_e;
endpackage

// file: rtl/sacp_sync3.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module sacp_sync3 (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Pin and clean level
  input wire logic pin_i,
  output logic level_o
);
  import sacp_pkg::*;

  logic ff1_r;
  logic ff2_r;
  logic ff3_r;

  // Chain; only the second stage reads the first
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ff1_r <= 1'b0;
      ff2_r <= 1'b0;
      ff3_r <= 1'b0;
    end else begin
      ff1_r <= pin_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_o <= 1'b0;
    end else if (ff2_r == ff3_r) begin
      level_o <= ff3_r;
    end
  end
endmodule

// file: rtl/sacp_avg4.sv
// Four-conversion averager with round-half-up
`timescale 1ns/1ps
module sacp_avg4 #(
  parameter int ADC_W = sacp_pkg::ADC_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Request from the parser
  input wire logic start_i,
  input wire logic [sacp_pkg::CHAN_W-1:0] chan_i,
  output logic done_o,
  output logic [ADC_W-1:0] avg_o,
  // Converter handshake
  output logic req_o,
  output logic [sacp_pkg::CHAN_W-1:0] chan_o,
  input wire logic ack_i,
  input wire logic [ADC_W-1:0] data_i
);
  import sacp_pkg::*;

  logic [AVG_SUM_W-1:0] sum_r;
  logic [1:0] cnt_r;
  logic [AVG_SUM_W-1:0] sum_nxt;
  logic [AVG_SUM_W-1:0] rnd;

  // Running sum; the fourth sample plus one half gives the rounded mean
  assign sum_nxt = sum_r + AVG_SUM_W'(data_i);
  assign rnd = sum_nxt + AVG_ROUND;

  // Hold the request across all four conversions of one channel
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_o <= 1'b0;
      chan_o <= '0;
      sum_r <= '0;
      cnt_r <= 2'd0;
      done_o <= 1'b0;
      avg_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        req_o <= 1'b1;
        chan_o <= chan_i;
        sum_r <= '0;
        cnt_r <= 2'd0;
      end else if (req_o && ack_i) begin
        sum_r <= sum_nxt;
        cnt_r <= cnt_r + 2'd1;
        if (cnt_r == 2'(AVG_N - 1)) begin
          req_o <= 1'b0;
          done_o <= 1'b1;
          avg_o <= rnd[AVG_SUM_W-1:2];
        end
      end
    end
  end
endmodule

// file: testbench/sacp_host_model.sv
// Host-side serial engine model: takes reply bytes, may stall
`timescale 1ns/1ps
module sacp_host_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Mode
  input wire logic slow_i,
  // Reply stream
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] got[$];

  // Slow mode offers ready every other cycle, so each byte must stand
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
    end
  end

  // A byte is taken only at an edge where valid and ready agree
  always @(posedge mclk_i) begin
    if (arst_n_i && tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
endmodule

// file: testbench/sacp_parser_test.sv
// Self-checking bench for the command parser
`timescale 1ns/1ps
module sacp_parser_test;
  import sacp_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic tx_ready_i;
  logic tx_valid_o;
  logic [7:0] tx_data_o;
  logic conv_req_o;
  logic [CHAN_W-1:0] conv_chan_o;
  logic conv_ack_i = 1'b0;
  logic [ADC_W-1:0] conv_data_i = 12'h000;
  logic din_i = 1'b0;
  logic dout_o;
  logic slow = 1'b0;
  logic dout_exp = 1'b0;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int gap = 0;
  int nack = 0;
  logic [7:0] frm[$];
  logic [7:0] exp[$];

  sacp_parser u_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o),
    .conv_ack_i(conv_ack_i), .conv_data_i(conv_data_i), .din_i(din_i),
    .dout_o(dout_o)
  );

  sacp_host_model u_host (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .slow_i(slow),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i)
  );

  // ----------------------------------------------------------------
  // Clock, converter model and hang limit
  // ----------------------------------------------------------------
  always #20 mclk_i = ~mclk_i;

  // Samples v, v+1, v+1, v: the mean sits on a half, so rounding shows
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    conv_ack_i <= 1'b0;
    if (conv_req_o && !conv_ack_i && gap >= 2) begin
      conv_ack_i <= 1'b1;
      conv_data_i <= {conv_chan_o, 8'hA5} + ((nack == 1 || nack == 2) ? 12'h001 : 12'h000);
      nack <= (nack + 1) % 4;
      gap <= 0;
    end else begin
      conv_data_i <= ~conv_data_i; // Stale data never looks valid
      gap <= gap + 1;
    end
    if (cycles == 30000) begin
      n_fail++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Sends frm back to back, then lets the reply count settle
  task automatic run(input int nexp);
    int i;
    u_host.got.delete();
    foreach (frm[k]) begin
      @(posedge mclk_i);
      rx_valid_i <= 1'b1;
      rx_data_i <= frm[k];
    end
    @(posedge mclk_i);
    rx_valid_i <= 1'b0;
    rx_data_i <= ~rx_data_i;
    for (i = 0; i < 400 && u_host.got.size() < nexp; i++) begin
      @(posedge mclk_i);
    end
    repeat (30) @(posedge mclk_i);
    chk(16'(u_host.got.size()), 16'(nexp));
    chk(16'({conv_req_o, tx_valid_o}), 16'h0000);
  endtask

  function automatic void push2(input logic [7:0] b, input logic ext);
    exp.push_back(b);
    if (ext) begin
      exp.push_back(~b);
    end
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Analog read: channels sel..0 (a test channel alone), result {ch,A6}
  task automatic t_analog(input logic [7:0] sel, input logic ext);
    int lo;
    exp.delete();
    lo = (sel > CHAN_MAX) ? int'(sel) : 0;
    for (int c = sel; c >= lo; c--) begin
      push2({4'h0, 4'(c)}, ext);
      push2(8'hA6, ext);
    end
    frm = {ext ? START_EXT : START_STD, MOD_ADDR, LTR_R, LTR_A, sel};
    if (ext) begin
      frm.push_back(~sel);
    end
    run(exp.size());
    foreach (exp[k]) begin
      if (k < u_host.got.size()) begin
        chk(u_host.got[k], exp[k]);
      end
    end
  endtask

  // Digital read; only bits 0 and 3 are judged
  task automatic t_dig(input logic din, input logic ext, input logic [7:0] lead);
    logic [7:0] b;
    din_i <= din;
    repeat (5) @(posedge mclk_i);
    frm = {lead, ext ? START_EXT : START_STD, MOD_ADDR, LTR_R, LTR_D};
    run(ext ? 2 : 1);
    if (u_host.got.size() > 0) begin
      chk(u_host.got[0] & 8'h09, {4'h0, din, 2'b00, dout_exp});
    end
    if (ext && u_host.got.size() > 1) begin
      b = ~u_host.got[0];
      chk(u_host.got[1], b);
    end
  endtask

  // Set output; a bad complement must leave the pin alone
  task automatic t_set(input logic [7:0] d, input logic ext, input logic good);
    frm = {ext ? START_EXT : START_STD, MOD_ADDR, LTR_S, LTR_O, d};
    if (ext) begin
      frm.push_back(good ? ~d : d);
    end
    if (!ext || good) begin
      dout_exp = d[0];
    end
    run(0);
    chk(dout_o, dout_exp);
  endtask

  // Broken frames produce no reply
  task automatic t_drop(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
    frm = {START_STD, a, LTR_R, c, d};
    run(0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk(dout_o, 1'b0);
    for (int n = 0; n <= 5; n++) begin
      t_analog(8'(n), 1'b0);
    end
    for (int n = 11; n <= 13; n++) begin
      t_analog(8'(n), 1'b0);
    end
    slow <= 1'b1;
    t_analog(8'h02, 1'b1);
    t_analog(TEST_LO, 1'b1);
    t_dig(1'b1, 1'b1, 8'h00);
    t_set(8'h01, 1'b0, 1'b1);
    t_dig(1'b0, 1'b1, 8'h00);
    slow <= 1'b0;
    t_set(8'hFE, 1'b0, 1'b1);
    t_dig(1'b1, 1'b0, 8'h00);
    t_set(8'h01, 1'b1, 1'b1);
    t_set(8'h00, 1'b1, 1'b0);
    t_dig(1'b0, 1'b0, START_STD);
    t_drop(8'h31, LTR_D, 8'h00);
    t_drop(MOD_ADDR, 8'h58, 8'h00);
    t_drop(MOD_ADDR, LTR_A, 8'h06);
    frm = {START_EXT, MOD_ADDR, LTR_R, LTR_A, 8'h02, 8'h02};
    run(0);
    close_out();
  end
endmodule
